// ==== testbench/gsc_command_map_assertions.sv ====
// Port-level checker for the gauge standard command map
`timescale 1ns/10ps
`default_nettype none

module gsc_command_map_assertions
    import gsc_pkg::*;
#(
    parameter logic [7:0] USER_SUBCLASS = USER_SUBCLASS_DEFAULT
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               srst,
    // Host byte port
    input wire gsc_host_req_type   hostReq,
    input wire logic               hostReady,
    input wire logic               hostDone,
    // Gauge state
    input wire logic               lockedAccessMode,
    input wire logic               refreshTick,
    input wire logic [15:0]        loadRateSetpoint,
    input wire gsc_power_mode_type powerMode,
    // Flash port
    input wire gsc_flash_req_type  flashReq,
    input wire logic               flashDone,
    input wire logic               flashRefused
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    wire take = hostReq.valid && hostReady;
    wire userLoc = flashReq.subclass == USER_SUBCLASS && flashReq.offset < FLASH_LIMIT;

    property p_take_done; take |=> hostDone; endproperty
    property p_done_cause; hostDone |-> $past(take); endproperty
    property p_ready_mode; hostReady == (powerMode == PM_NORMAL); endproperty
    property p_wait_bound; hostReq.valid && !hostReady |-> ##[1:3] hostReady; endproperty
    property p_tick_pulse; refreshTick |=> !refreshTick; endproperty
    // The working copy may only move right behind a refresh pulse
    property p_rate_refresh;
        !$stable(loadRateSetpoint) |-> $past(refreshTick) || $past(refreshTick, 2);
    endproperty
    property p_flash_done; flashReq.valid |=> flashDone; endproperty
    property p_flash_bad; flashReq.valid && !userLoc |=> flashRefused; endproperty
    property p_flash_lock; flashReq.valid && flashReq.write && lockedAccessMode |=> flashRefused;
    endproperty
    property p_flash_good;
        flashReq.valid && userLoc && !(flashReq.write && lockedAccessMode) |=> !flashRefused;
    endproperty
    property p_mode_onehot; $onehot(powerMode); endproperty
    property p_hib_wake; powerMode == PM_HIBERNATE && hostReq.valid |=> powerMode == PM_NORMAL;
    endproperty

    a_take_done: assert property (p_take_done) else $error("no done after take");
    a_done_cause: assert property (p_done_cause) else $error("done without take");
    a_ready_mode: assert property (p_ready_mode) else $error("ready not tied to mode");
    a_wait_bound: assert property (p_wait_bound) else $error("request not woken");
    a_tick_pulse: assert property (p_tick_pulse) else $error("refresh tick too long");
    a_rate_refresh: assert property (p_rate_refresh) else $error("rate moved off refresh");
    a_flash_done: assert property (p_flash_done) else $error("flash done missing");
    a_flash_bad: assert property (p_flash_bad) else $error("bad location taken");
    a_flash_lock: assert property (p_flash_lock) else $error("locked write taken");
    a_flash_good: assert property (p_flash_good) else $error("user byte refused");
    a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");
    a_hib_wake: assert property (p_hib_wake) else $error("no wake from hibernate");

    c_take: cover property (take && !hostReq.write);
    c_tick: cover property (refreshTick);
    c_refused: cover property (flashRefused);
    c_hib: cover property (powerMode == PM_HIBERNATE);
endmodule // gsc_command_map_assertions

bind gsc_command_map gsc_command_map_assertions #(.USER_SUBCLASS(USER_SUBCLASS))
    i_gsc_command_map_assertions (.clk(clk), .srst(srst), .hostReq(hostReq),
    .hostReady(hostReady), .hostDone(hostDone), .lockedAccessMode(lockedAccessMode),
    .refreshTick(refreshTick), .loadRateSetpoint(loadRateSetpoint), .powerMode(powerMode),
    .flashReq(flashReq), .flashDone(flashDone), .flashRefused(flashRefused));
`default_nettype wire

// ==== testbench/gsc_command_map_tb.sv ====
// Self-checking testbench for the gauge standard command map
`timescale 1ns/10ps
`default_nettype none

module gsc_command_map_tb;
    import gsc_pkg::*;

    logic                       clk = 1'b0;
    logic                       srst = 1'b1;
    gsc_host_req_type           hostReq;
    logic                       hostReady, hostDone, refreshTick, flashDone, flashRefused;
    logic [7:0]                 hostRdData, flashRdData, rdByte;
    logic [NUM_WORDS-1:0][15:0] gaugeWords;
    logic                       lockedAccessMode = 1'b0;
    gsc_mode_events_type        modeEvents = '0;
    logic [15:0]                controlWord, loadRateSetpoint;
    gsc_power_mode_type         powerMode;
    gsc_flash_req_type          flashReq = '0;
    int                         bad_count = 0;
    int                         cmp_count = 0;

    always #10 clk = ~clk;

    gsc_command_map #(.REFRESH_COUNT(16), .USER_SUBCLASS(USER_SUBCLASS_DEFAULT)) i_gsc_command_map (
        .clk(clk), .srst(srst), .hostReq(hostReq), .hostReady(hostReady),
        .hostDone(hostDone), .hostRdData(hostRdData), .gaugeWords(gaugeWords),
        .lockedAccessMode(lockedAccessMode), .modeEvents(modeEvents),
        .refreshTick(refreshTick), .controlWord(controlWord),
        .loadRateSetpoint(loadRateSetpoint), .powerMode(powerMode), .flashReq(flashReq),
        .flashDone(flashDone), .flashRefused(flashRefused), .flashRdData(flashRdData));

    gsc_host_model i_gsc_host_model (.clk(clk), .hostReq(hostReq), .hostReady(hostReady),
        .hostDone(hostDone), .hostRdData(hostRdData));

    function automatic logic [15:0] wordOf(int i);
        return {8'h80 + 8'(i), 8'(i) ^ 8'h5A};
    endfunction

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(input logic wr, input logic [7:0] code, input logic [7:0] din);
        logic ok;
        i_gsc_host_model.xfer(wr, code, din, rdByte, ok);
        if (!ok) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic waitTick();
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (refreshTick === 1'b1)
                return;
        end
        bad_count++;
        report_and_stop();
    endtask

    task automatic fl(input logic wr, input logic [7:0] sub, input logic [7:0] off,
                      input logic [7:0] din, input logic expRef, input logic [7:0] expData);
        @(posedge clk);
        flashReq <= '{valid: 1'b1, write: wr, subclass: sub, offset: off, data: din};
        @(posedge clk);
        flashReq <= '{valid: 1'b0, write: ~wr, subclass: ~sub, offset: ~off, data: ~din};
        @(posedge clk);
        chk("flashDone", 16'(flashDone), 16'h0001);
        chk("flashRefused", 16'(flashRefused), 16'(expRef));
        if (!wr)
            chk("flashRdData", 16'(flashRdData), 16'(expData));
    endtask

    initial begin
        int i;
        logic [15:0] exp;
        logic [7:0] offs [3] = '{8'h00, 8'h25, 8'h5F};
        for (i = 0; i < NUM_WORDS; i++)
            gaugeWords[i] = wordOf(i);
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("hostReady", 16'(hostReady), 16'h0001);
        chk("powerMode", 16'(powerMode), 16'(PM_NORMAL));
        chk("controlWord", controlWord, 16'h0000);
        acc(1'b0, CODE_CELL_POTENTIAL_MV, 8'h00);
        chk("stale word", 16'(rdByte), 16'h0000);
        waitTick();
        repeat (2) @(posedge clk);
        // Bytes 0x04 to 0x37 of the map, gaps included
        for (i = 4; i < 56; i++) begin
            acc(1'b0, 8'(i), 8'h00);
            exp = wordOf(i / 2) >> (8 * (i % 2));
            if (!WORD_PRESENT_MASK[i / 2])
                exp = '0;
            chk("map byte", 16'(rdByte), {8'h00, exp[7:0]});
        end
        // Start right after a refresh so no reload can hide a write that must not land
        waitTick();
        acc(1'b1, CODE_CELL_POTENTIAL_MV, 8'h55);
        acc(1'b0, CODE_CELL_POTENTIAL_MV, 8'h00);
        chk("unlocked override", 16'(rdByte), 16'h0055);
        lockedAccessMode <= 1'b1;
        acc(1'b1, CODE_CELL_POTENTIAL_MV + 8'h01, 8'h55);
        acc(1'b0, CODE_CELL_POTENTIAL_MV + 8'h01, 8'h00);
        chk("locked ro write", 16'(rdByte), 16'(wordOf(4) >> 8));
        waitTick();
        acc(1'b1, CODE_CONTROL_WORD, 8'h34);
        acc(1'b1, CODE_CONTROL_WORD + 8'h01, 8'h12);
        acc(1'b1, CODE_LOAD_RATE_SETPOINT, 8'hF6);
        acc(1'b1, CODE_LOAD_RATE_SETPOINT + 8'h01, 8'hFF);
        chk("controlWord early", controlWord, 16'h0000);
        acc(1'b0, CODE_CONTROL_WORD + 8'h01, 8'h00);
        chk("control high", 16'(rdByte), 16'h0012);
        acc(1'b0, CODE_LOAD_RATE_SETPOINT, 8'h00);
        chk("rate low", 16'(rdByte), 16'h00F6);
        waitTick();
        repeat (2) @(posedge clk);
        chk("controlWord", controlWord, 16'h1234);
        chk("loadRateSetpoint", loadRateSetpoint, 16'hFFF6);
        fl(1'b1, USER_SUBCLASS_DEFAULT, 8'h10, 8'hAA, 1'b1, 8'h00);
        lockedAccessMode <= 1'b0;
        for (i = 0; i < 3; i++) begin
            fl(1'b1, USER_SUBCLASS_DEFAULT, offs[i], offs[i] ^ 8'hC3, 1'b0, 8'h00);
            fl(1'b0, USER_SUBCLASS_DEFAULT, offs[i], 8'h00, 1'b0, offs[i] ^ 8'hC3);
        end
        fl(1'b1, USER_SUBCLASS_DEFAULT, FLASH_LIMIT, 8'h11, 1'b1, 8'h00);
        fl(1'b0, USER_SUBCLASS_DEFAULT + 8'h01, 8'h25, 8'h00, 1'b1, 8'h00);
        lockedAccessMode <= 1'b1;
        fl(1'b0, USER_SUBCLASS_DEFAULT, 8'h25, 8'h00, 1'b0, 8'hE6);
        lockedAccessMode <= 1'b0;
        modeEvents.sleepCondition <= 1'b1;
        repeat (3) @(posedge clk);
        chk("sleep mode", 16'(powerMode), 16'(PM_SLEEP));
        chk("asleep ready", 16'(hostReady), 16'h0000);
        modeEvents.deepIdleEnable <= 1'b1;
        repeat (3) @(posedge clk);
        chk("deep idle", 16'(powerMode), 16'(PM_DEEP_IDLE));
        acc(1'b0, CODE_STATE_OF_CHARGE, 8'h00);
        chk("woken read", 16'(rdByte), 16'(wordOf(22) & 16'h00FF));
        modeEvents.deepIdleEnable <= 1'b0;
        modeEvents.hibernateRequest <= 1'b1;
        repeat (4) @(posedge clk);
        chk("hibernate", 16'(powerMode), 16'(PM_HIBERNATE));
        modeEvents <= '{wakeEvent: 1'b1, default: 1'b0};
        repeat (2) @(posedge clk);
        chk("woken mode", 16'(powerMode), 16'(PM_NORMAL));
        modeEvents <= '{sleepCondition: 1'b1, hibernateRequest: 1'b1, default: 1'b0};
        repeat (3) @(posedge clk);
        chk("hibernate again", 16'(powerMode), 16'(PM_HIBERNATE));
        acc(1'b0, CODE_PASSED_CHARGE + 8'h01, 8'h00);
        chk("hibernate read", 16'(rdByte), 16'(wordOf(26) >> 8));
        modeEvents <= '0;
        report_and_stop();
    end
endmodule // gsc_command_map_tb
`default_nettype wire

// ==== testbench/gsc_host_model.sv ====
// Host processor model issuing byte requests to the command map
`timescale 1ns/10ps
`default_nettype none

module gsc_host_model
    import gsc_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Byte port
    output gsc_host_req_type      hostReq,
    input  wire logic             hostReady,
    input  wire logic             hostDone,
    input  wire logic [7:0]       hostRdData
);
    initial hostReq = '0;

    // Held until taken; released lines show the inverse so stale values never pass
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] din,
                        output logic [7:0] dout, output logic ok);
        int n;
        ok = 1'b0;
        dout = 8'h00;
        @(posedge clk);
        hostReq <= '{valid: 1'b1, write: wr, code: code, data: din};
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = (hostReady === 1'b1);
        end
        hostReq <= '{valid: 1'b0, write: ~wr, code: ~code, data: ~din};
        if (ok) begin
            @(posedge clk);
            ok = (hostDone === 1'b1);
            dout = hostRdData;
        end
    endtask
endmodule // gsc_host_model
`default_nettype wire

// ==== verilog/gsc_command_map.sv ====
// Gauge standard command map: byte command codes, refresh, user flash, power modes
//
// Behaviour
// - Every command is a code pair holding one 16-bit value.
// - Results refresh and host-written values are sampled once per second only.
// - Commands are serviced in normal mode; other modes wake first.
// - Control word at 0x00/0x01, read and write even when locked.
// - Rate setpoint at 0x02/0x03 read/write; time at that rate at 0x04.
// - Pack temperature at 0x06, die temperature at 0x28, read only when locked.
// - Cell voltage at 0x08, condition flags at 0x0A, read only when locked.
// - Capacities at 0x0C, 0x0E, 0x10, 0x12; passed charge 0x34.
// - Times at 0x16, 0x18, 0x1C, 0x20 and 0x26, read only when locked.
// - Currents at 0x14, 0x1A and 0x1E, read only when locked.
// - Energy at 0x22 and power at 0x24, read only when locked.
// - Cycle count 0x2A, charge 0x2C, health 0x2E, initial discharge 0x36.
// - 96 bytes user flash as three 32-byte blocks via flash port.
// - Flash location is named by subclass and offset together.
// - Other parameter locations refused; locked mode refuses flash writes.
// - Modes normal, sleep, deep idle, hibernate change on events.
`timescale 1ns/10ps
`default_nettype none

module gsc_command_map
    import gsc_pkg::*;
#(
    parameter longint unsigned REFRESH_COUNT = REFRESH_CYCLES,
    parameter logic [7:0]      USER_SUBCLASS = USER_SUBCLASS_DEFAULT
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              srst,
    // Serial engine byte access
    input  wire gsc_host_req_type                  hostReq,
    output logic                                   hostReady,
    output logic                                   hostDone,
    output logic [7:0]                             hostRdData,
    // Gauge core results and state
    input  wire logic [NUM_WORDS-1:0][15:0]        gaugeWords,
    input  wire logic                              lockedAccessMode,
    input  wire gsc_mode_events_type               modeEvents,
    output logic                                   refreshTick,
    output logic [15:0]                            controlWord,
    output logic [15:0]                            loadRateSetpoint,
    output gsc_power_mode_type                     powerMode,
    // Parameter flash access
    input  wire gsc_flash_req_type                 flashReq,
    output logic                                   flashDone,
    output logic                                   flashRefused,
    output logic [7:0]                             flashRdData
);

    // Refresh timer
    logic [TICK_WIDTH-1:0]  tickCount_reg;
    logic                   tickHit;
    logic                   refreshTick_reg;

    // Command image
    logic [15:0]            wordImage [NUM_WORDS];
    logic [15:0]            controlWord_reg;
    logic [15:0]            loadRate_reg;

    // Host byte port
    logic                   hostAccept;
    logic                   hostWrite;
    logic [WORD_IDX_WIDTH-1:0] wordIdx;
    logic                   codeInRange;
    logic                   wordMapped;
    logic                   wordWritable;
    logic                   writeAllowed;
    logic [15:0]            selectedWord;
    logic [7:0]             selectedByte;
    logic                   hostReady_reg;
    logic                   hostDone_reg;
    logic [7:0]             hostRdData_reg;

    // Power mode
    gsc_power_mode_type     powerMode_reg;
    gsc_power_mode_type     powerMode_next;
    logic                   hostWake;

    // User flash
    logic [7:0]             flashMem [FLASH_BYTES];
    logic                   flashInRange;
    logic                   flashSubclassOk;
    logic                   flashRefuse;
    logic                   flashDoWrite;
    logic [1:0]             flashBlock;
    logic [4:0]             flashInner;
    logic                   flashDone_reg;
    logic                   flashRefused_reg;
    logic [7:0]             flashRdData_reg;

    // ---------------------------------------------------------------
    // Once-per-second refresh tick
    // ---------------------------------------------------------------
    assign tickHit = (tickCount_reg == TICK_WIDTH'(REFRESH_COUNT - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            tickCount_reg   <= '0;
            refreshTick_reg <= 1'b0;
        end else begin
            tickCount_reg   <= tickHit ? '0 : tickCount_reg + 1'b1;
            refreshTick_reg <= tickHit;
        end
    end

    // ---------------------------------------------------------------
    // Host byte decode
    // ---------------------------------------------------------------
    // Requests are held off by hostReady until the gauge is back in normal mode
    assign hostAccept   = hostReq.valid && hostReady_reg;
    assign hostWrite    = hostAccept && hostReq.write;
    assign wordIdx      = hostReq.code[5:1];
    assign codeInRange  = (hostReq.code[7:6] == 2'b00);
    assign wordMapped   = codeInRange && WORD_PRESENT_MASK[wordIdx];
    assign wordWritable = WORD_WRITABLE_MASK[wordIdx];
    // Outside locked mode a read-only word may be overwritten until the next refresh
    assign writeAllowed = hostWrite && wordMapped
                          && (wordWritable || !lockedAccessMode);
    assign selectedWord = wordMapped ? wordImage[wordIdx] : WORD_RESET;
    assign selectedByte = hostReq.code[0] ? selectedWord[15:8] : selectedWord[7:0];

    // ---------------------------------------------------------------
    // Command image, one word per code pair
    // ---------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_WORDS; i++) begin : gWord
            if (!WORD_PRESENT_MASK[i]) begin : gAbsent
                assign wordImage[i] = WORD_RESET;
            end else begin : gPresent
                logic        hitLow;
                logic        hitHigh;
                logic [15:0] word_reg;
                // One local flop per word keeps every array element to a single driver
                assign wordImage[i] = word_reg;
                assign hitLow  = writeAllowed && (wordIdx == WORD_IDX_WIDTH'(i))
                                 && !hostReq.code[0];
                assign hitHigh = writeAllowed && (wordIdx == WORD_IDX_WIDTH'(i))
                                 && hostReq.code[0];
                always_ff @(posedge clk) begin
                    if (srst) begin
                        word_reg <= WORD_RESET;
                    end else if (!WORD_WRITABLE_MASK[i] && refreshTick_reg) begin
                        // Fresh results win over a stale host override
                        word_reg <= gaugeWords[i];
                    end else begin
                        if (hitLow) begin
                            word_reg[7:0] <= hostReq.data;
                        end
                        if (hitHigh) begin
                            word_reg[15:8] <= hostReq.data;
                        end
                    end
                end
            end
        end
    endgenerate

    // Time at the host rate is computed by the core from the sampled setpoint below
    always_ff @(posedge clk) begin
        if (srst) begin
            controlWord_reg <= WORD_RESET;
            loadRate_reg    <= WORD_RESET;
        end else if (refreshTick_reg) begin
            controlWord_reg <= wordImage[IDX_CONTROL_WORD];
            loadRate_reg    <= wordImage[IDX_LOAD_RATE];
        end
    end

    // ---------------------------------------------------------------
    // Host answer: one cycle after the accepting edge
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            hostDone_reg   <= 1'b0;
            hostRdData_reg <= BYTE_RESET;
        end else begin
            hostDone_reg <= hostAccept;
            if (hostAccept && !hostReq.write) begin
                hostRdData_reg <= selectedByte;
            end
        end
    end

    // ---------------------------------------------------------------
    // Power mode sequencing
    // ---------------------------------------------------------------
    // A held request is itself the wake event; deep idle drops to sleep first
    assign hostWake = hostReq.valid || flashReq.valid;

    always_comb begin
        powerMode_next = powerMode_reg;
        unique case (powerMode_reg)
            PM_NORMAL: begin
                if (modeEvents.sleepCondition && !hostWake) begin
                    powerMode_next = PM_SLEEP;
                end
            end
            PM_SLEEP: begin
                if (hostWake || !modeEvents.sleepCondition || modeEvents.wakeEvent) begin
                    powerMode_next = PM_NORMAL;
                end else if (modeEvents.hibernateRequest) begin
                    powerMode_next = PM_HIBERNATE;
                end else if (modeEvents.deepIdleEnable) begin
                    powerMode_next = PM_DEEP_IDLE;
                end
            end
            PM_DEEP_IDLE: begin
                if (hostWake || modeEvents.wakeEvent || !modeEvents.sleepCondition) begin
                    powerMode_next = PM_SLEEP;
                end
            end
            PM_HIBERNATE: begin
                if (hostWake || modeEvents.wakeEvent) begin
                    powerMode_next = PM_NORMAL;
                end
            end
            default: begin
                powerMode_next = PM_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            powerMode_reg <= PM_NORMAL;
            hostReady_reg <= 1'b1;
        end else begin
            powerMode_reg <= powerMode_next;
            hostReady_reg <= (powerMode_next == PM_NORMAL);
        end
    end

    // ---------------------------------------------------------------
    // User flash: subclass plus offset, three 32-byte blocks
    // ---------------------------------------------------------------
    assign flashSubclassOk = (flashReq.subclass == USER_SUBCLASS);
    assign flashInRange    = (flashReq.offset < FLASH_LIMIT);
    assign flashBlock      = flashReq.offset[6:5];
    assign flashInner      = flashReq.offset[4:0];
    // Served even outside normal mode: this port never waits on the mode machine
    assign flashRefuse     = !flashSubclassOk || !flashInRange
                             || (flashReq.write && lockedAccessMode);
    assign flashDoWrite    = flashReq.valid && flashReq.write && !flashRefuse;

    // Non-volatile content is not cleared by reset
    always_ff @(posedge clk) begin
        if (flashDoWrite) begin
            flashMem[{flashBlock, flashInner}] <= flashReq.data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flashDone_reg    <= 1'b0;
            flashRefused_reg <= 1'b0;
            flashRdData_reg  <= BYTE_RESET;
        end else begin
            flashDone_reg    <= flashReq.valid;
            flashRefused_reg <= flashReq.valid && flashRefuse;
            if (flashReq.valid && !flashReq.write) begin
                flashRdData_reg <= flashRefuse ? BYTE_RESET
                                               : flashMem[{flashBlock, flashInner}];
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign hostReady        = hostReady_reg;
    assign hostDone         = hostDone_reg;
    assign hostRdData       = hostRdData_reg;
    assign refreshTick      = refreshTick_reg;
    assign controlWord      = controlWord_reg;
    assign loadRateSetpoint = loadRate_reg;
    assign powerMode        = powerMode_reg;
    assign flashDone        = flashDone_reg;
    assign flashRefused     = flashRefused_reg;
    assign flashRdData      = flashRdData_reg;

endmodule // gsc_command_map

`default_nettype wire

// ==== verilog/gsc_pkg.sv ====
// Constants and types shared by the gauge standard command map
package gsc_pkg;

    // Command code pairs: the low code carries the low byte of a 16-bit word
    localparam int unsigned NUM_WORDS      = 32;
    localparam int unsigned WORD_IDX_WIDTH = 5;
    localparam logic [7:0] CODE_CONTROL_WORD          = 8'h00;
    localparam logic [7:0] CODE_LOAD_RATE_SETPOINT    = 8'h02;
    localparam logic [7:0] CODE_RATE_BASED_EMPTY_TIME = 8'h04;
    localparam logic [7:0] CODE_THERMISTOR_READING    = 8'h06;
    localparam logic [7:0] CODE_CELL_POTENTIAL_MV     = 8'h08;
    localparam logic [7:0] CODE_GAUGE_CONDITION_BITS  = 8'h0A;
    localparam logic [7:0] CODE_NOMINAL_AVAIL_CAP     = 8'h0C;
    localparam logic [7:0] CODE_FULL_AVAIL_CAP        = 8'h0E;
    localparam logic [7:0] CODE_CHARGE_LEFT           = 8'h10;
    localparam logic [7:0] CODE_FULL_CHARGE_CAPACITY  = 8'h12;
    localparam logic [7:0] CODE_MEAN_CURRENT          = 8'h14;
    localparam logic [7:0] CODE_TIME_TO_EMPTY         = 8'h16;
    localparam logic [7:0] CODE_TIME_TO_FULL          = 8'h18;
    localparam logic [7:0] CODE_STANDBY_CURRENT       = 8'h1A;
    localparam logic [7:0] CODE_STANDBY_TIME_TO_EMPTY = 8'h1C;
    localparam logic [7:0] CODE_MAX_LOAD_CURRENT      = 8'h1E;
    localparam logic [7:0] CODE_MAX_LOAD_EMPTY_TIME   = 8'h20;
    localparam logic [7:0] CODE_AVAILABLE_ENERGY      = 8'h22;
    localparam logic [7:0] CODE_AVERAGE_POWER         = 8'h24;
    localparam logic [7:0] CODE_CONST_POWER_EMPTY     = 8'h26;
    localparam logic [7:0] CODE_DIE_SENSOR_TEMP       = 8'h28;
    localparam logic [7:0] CODE_CYCLE_COUNT           = 8'h2A;
    localparam logic [7:0] CODE_STATE_OF_CHARGE       = 8'h2C;
    localparam logic [7:0] CODE_STATE_OF_HEALTH       = 8'h2E;
    localparam logic [7:0] CODE_PASSED_CHARGE         = 8'h34;
    localparam logic [7:0] CODE_INIT_DEPTH_DISCHARGE  = 8'h36;

    // Word index = code / 2; bit set where a command exists, and where it is host-writable
    localparam logic [31:0] WORD_PRESENT_MASK  = 32'h0CFF_FFFF;
    localparam logic [31:0] WORD_WRITABLE_MASK = 32'h0000_0003;
    localparam logic [4:0]  IDX_CONTROL_WORD   = 5'h00;
    localparam logic [4:0]  IDX_LOAD_RATE      = 5'h01;

    // Reset values
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;

    // User flash: three blocks of 32 bytes
    localparam int unsigned FLASH_BLOCKS      = 3;
    localparam int unsigned FLASH_BLOCK_BYTES = 32;
    localparam int unsigned FLASH_BYTES       = FLASH_BLOCKS * FLASH_BLOCK_BYTES;
    localparam logic [7:0]  FLASH_LIMIT       = 8'h60;
    // Subclass of the user blocks; arbitrary value
    localparam logic [7:0]  USER_SUBCLASS_DEFAULT = 8'h40;

    // Refresh period
    localparam longint unsigned REFRESH_PERIOD_MS = 1000;
    localparam longint unsigned CLK_PERIOD_NS     = 20;
    localparam longint unsigned REFRESH_CYCLES =
        (REFRESH_PERIOD_MS * 64'd1000000) / CLK_PERIOD_NS;
    localparam int unsigned TICK_WIDTH = 32;

    // Power modes
    typedef enum logic [3:0] {
        PM_NORMAL    = 4'b0001,
        PM_SLEEP     = 4'b0010,
        PM_DEEP_IDLE = 4'b0100,
        PM_HIBERNATE = 4'b1000
    } gsc_power_mode_type;

    // Byte access from the serial engine
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } gsc_host_req_type;

    // Parameter flash access
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] subclass;
        logic [7:0] offset;
        logic [7:0] data;
    } gsc_flash_req_type;

    // Power mode events from the gauge core
    typedef struct packed {
        logic sleepCondition;
        logic deepIdleEnable;
        logic hibernateRequest;
        logic wakeEvent;
    } gsc_mode_events_type;

endpackage
